// ==== logic/cctr_pkg.sv ====
/*
  shared constants for the codec clock, timer and interrupt register slice:
  register offsets, field positions, reset values and timing counts.
  assumes an 8-bit register space addressed by an 8-bit index.
*/
package cctr_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CLK_CTRL = 8'h13;
  localparam logic [7:0] OFS_DAC_SEL = 8'h14;
  localparam logic [7:0] OFS_TUNE_HI = 8'h15;
  localparam logic [7:0] OFS_TUNE_LO = 8'h16;
  localparam logic [7:0] OFS_ADC_SEL = 8'h17;
  localparam logic [7:0] OFS_TMR_HI = 8'h18;
  localparam logic [7:0] OFS_TMR_LO = 8'h19;
  localparam logic [7:0] OFS_IRQ_FORM = 8'h1A;
  localparam logic [7:0] OFS_MASK1 = 8'h1B;
  localparam logic [7:0] OFS_FLAG1 = 8'h1C;
  localparam logic [7:0] OFS_MASK2 = 8'h1D;
  localparam logic [7:0] OFS_FLAG2 = 8'h1E;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_CLK_DIV = 6;
  localparam int BIT_CLK_GATE = 4;
  localparam int BIT_TUNE_EN = 7;
  localparam int BIT_HPF = 6;
  localparam int BIT_LOCK = 7;
  localparam int BIT_ADC_MUTE = 2;
  localparam int BIT_DAC_MUTE = 0;
  localparam int BIT_TIMER_END = 4;

  // ----------------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------------
  localparam logic RST_CLK_DIV = 1'b1;
  localparam logic RST_MASK = 1'b1;
  localparam logic [3:0] FREQ_12MHZ = 4'h0;
  localparam logic [3:0] FREQ_13MHZ = 4'h2;
  localparam logic [7:0] MASK1_RSVD = 8'h7A; // bits 6:3 and 1 read one
  localparam logic [7:0] MASK2_RSVD = 8'hEF; // all but bit 4 read one

  typedef enum logic [1:0] {
    CCTR_IRQ_LVL_HIGH = 2'b00,
    CCTR_IRQ_LVL_LOW = 2'b01,
    CCTR_IRQ_PLS_HIGH = 2'b10,
    CCTR_IRQ_PLS_LOW = 2'b11
  } cctr_irq_form_t;

  // ----------------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------------
  localparam int SLOW_CLK_DIV = 256; // master clocks per timer tick
  localparam int IRQ_PULSE_LEN = 8; // pulse length in counting clocks

endpackage : cctr_pkg

// ==== logic/cctr_regs.sv ====
/*
  codec clock control, sample-rate selection, slow timer and interrupt
  register slice. software reaches it through a simple synchronous
  register port on mclk (the codec control interface front end is outside).
  assumes lock and mute inputs come from logic on mclk; the parallel
  interface clock arrives from a pin and is synchronised here.
*/
`timescale 1ns/10ps

// Operation
// - divider bit: clear passes, set halves clock
// - DAC rate code from low nibble
// - 15-bit DAC tuning word across two registers
// - tuning applies only when enabled, master mode
// - ADC high-pass enable bit switches filter
// - ADC rate code from low nibble
// - 16-bit timer load, high then low byte
// - timer ticks per 256 clocks, event at 1->0
// - IRQ form: levels, pulses of eight cycles
// - pulse counted in parallel or master clocks
// - first mask: lock, ADC mute, DAC mute
// - masked event still sets its flag
// - level IRQ inactive with no unmasked flag
// - pulse on new unmasked event or unmask
// - flags set on event, write-one clears
// - mute flags set at mute start and end
// - second mask bit 4 blocks timer flag from irq
// - reserved mask bits read one, ignore writes
// - timer-end flag, write-one clears
module cctr_regs #(
  parameter int TUNE_W = 15 // tuning word width
) (
  input wire logic mclk, // master clock, 250 MHz
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
  input wire logic parallel_port_sel, // 1: parallel interface in use, 0: SMB
  input wire logic parallel_port_clock, // parallel interface clock pin
  input wire logic master_mode, // converter in master mode
  input wire logic lock_event, // lock event pulse
  input wire logic adc_mute_active, // ADC soft mute level
  input wire logic dac_mute_active, // DAC soft mute level
  output logic master_clock_out, // divided or gated master clock
  output logic [3:0] master_clock_freq_sel, // frequency code
  output logic master_clock_freq_rsvd, // code is reserved
  output logic [3:0] dac_rate_code, // DAC sample-rate code
  output logic [3:0] adc_rate_code, // ADC sample-rate code
  output logic adc_highpass_enable, // ADC high-pass filter on
  output logic [TUNE_W-1:0] dac_tune_word, // effective tuning word
  output logic dac_tune_active, // tuning in effect
  output logic timer_end_pulse, // one-cycle timer end event
  output logic irq_out // interrupt line
);
  import cctr_pkg::*;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic clk_div;
  logic master_clock_gate;
  logic [3:0] freq_sel;
  logic [3:0] dac_sel;
  logic dac_tune_enable;
  logic [TUNE_W-1:0] tune_word;
  logic hpf;
  logic [3:0] adc_sel;
  logic [7:0] tmr_hi;
  logic [7:0] tmr_lo;
  cctr_irq_form_t irq_waveform_sel;
  logic [7:0] event_masks; // only bits 7, 2, 0 stored
  logic [7:0] event_masks2; // only bit 4 stored
  logic [7:0] event_flags;
  logic [7:0] event_flags2;
  logic [7:0] next_flags;
  logic [7:0] next_flags2;
  logic div_phase;
  logic [15:0] timer_cnt;
  logic [7:0] prescale;
  logic slow_tick;
  logic timer_end;
  logic adc_mute_d;
  logic dac_mute_d;
  logic pclk_s1;
  logic pclk_s2;
  logic pclk_s3;
  logic pulse_tick;
  logic [3:0] pulse_cnt;
  logic pending;
  logic [15:0] unmasked;
  logic [15:0] unmasked_d;
  logic [3:0] next_pulse_cnt;
  logic trigger;

  // unmasked pending, both flag registers treated alike
  function automatic logic any_pending(input logic [7:0] f1, input logic [7:0] m1,
                                       input logic [7:0] f2, input logic [7:0] m2);
    any_pending = |(f1 & ~m1) | |(f2 & ~m2);
  endfunction : any_pending

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = reg_wr && (reg_addr == ofs);
  endfunction : wr_hit

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  // writable fields; reserved bits simply are not stored
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clk_div <= RST_CLK_DIV;
      master_clock_gate <= 1'b0;
      freq_sel <= FREQ_12MHZ;
      dac_sel <= 4'h0;
      dac_tune_enable <= 1'b0;
      tune_word <= '0;
      hpf <= 1'b0;
      adc_sel <= 4'h0;
      tmr_hi <= 8'h00;
      tmr_lo <= 8'h00;
      irq_waveform_sel <= CCTR_IRQ_LVL_HIGH;
      event_masks <= 8'h00;
      event_masks2 <= 8'h00;
      event_masks[BIT_LOCK] <= RST_MASK;
      event_masks[BIT_ADC_MUTE] <= RST_MASK;
      event_masks[BIT_DAC_MUTE] <= RST_MASK;
      event_masks2[BIT_TIMER_END] <= RST_MASK;
    end else begin
      if (wr_hit(OFS_CLK_CTRL)) begin
        clk_div <= reg_wdata[BIT_CLK_DIV];
        master_clock_gate <= reg_wdata[BIT_CLK_GATE];
        freq_sel <= reg_wdata[3:0];
      end
      if (wr_hit(OFS_DAC_SEL)) begin
        dac_sel <= reg_wdata[3:0];
      end
      if (wr_hit(OFS_TUNE_HI)) begin
        dac_tune_enable <= reg_wdata[BIT_TUNE_EN];
        tune_word[TUNE_W-1:8] <= reg_wdata[TUNE_W-9:0];
      end
      if (wr_hit(OFS_TUNE_LO)) begin
        tune_word[7:0] <= reg_wdata;
      end
      if (wr_hit(OFS_ADC_SEL)) begin
        hpf <= reg_wdata[BIT_HPF];
        adc_sel <= reg_wdata[3:0];
      end
      if (wr_hit(OFS_TMR_HI)) begin
        tmr_hi <= reg_wdata;
      end
      if (wr_hit(OFS_TMR_LO)) begin
        tmr_lo <= reg_wdata;
      end
      if (wr_hit(OFS_IRQ_FORM)) begin
        irq_waveform_sel <= cctr_irq_form_t'(reg_wdata[7:6]);
      end
      if (wr_hit(OFS_MASK1)) begin
        event_masks[BIT_LOCK] <= reg_wdata[BIT_LOCK];
        event_masks[BIT_ADC_MUTE] <= reg_wdata[BIT_ADC_MUTE];
        event_masks[BIT_DAC_MUTE] <= reg_wdata[BIT_DAC_MUTE];
      end
      if (wr_hit(OFS_MASK2)) begin
        event_masks2[BIT_TIMER_END] <= reg_wdata[BIT_TIMER_END];
      end
    end
  end

  // ----------------------------------------------------------------------
  // clock divider and gate
  // ----------------------------------------------------------------------
  // phase toggles only while running; gating clears it to zero and the gate forces the output low
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_phase <= 1'b0;
    end else if (master_clock_gate) begin
      div_phase <= 1'b0;
    end else begin
      div_phase <= ~div_phase;
    end
  end

  // limitation: switching the divide bit mid-period can give one short
  // phase; software should change it with the clock gated
  assign master_clock_out = master_clock_gate ? 1'b0 : (clk_div ? div_phase : mclk);
  assign master_clock_freq_sel = freq_sel;
  assign master_clock_freq_rsvd = (freq_sel != FREQ_12MHZ) && (freq_sel != FREQ_13MHZ);

  // ----------------------------------------------------------------------
  // rate outputs
  // ----------------------------------------------------------------------
  // codes go out untouched; the rate table lives in the converters
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dac_rate_code <= 4'h0;
      adc_rate_code <= 4'h0;
      adc_highpass_enable <= 1'b0;
      dac_tune_active <= 1'b0;
      dac_tune_word <= '0;
    end else begin
      dac_rate_code <= dac_sel;
      adc_rate_code <= adc_sel;
      adc_highpass_enable <= hpf;
      dac_tune_active <= dac_tune_enable && master_mode;
      dac_tune_word <= (dac_tune_enable && master_mode) ? tune_word : '0;
    end
  end

  // ----------------------------------------------------------------------
  // slow timer
  // ----------------------------------------------------------------------
  assign slow_tick = (prescale == 8'(SLOW_CLK_DIV - 1));
  assign timer_end = slow_tick && (timer_cnt == 16'h0001);

  // free-running prescaler; a load does not restart it, so the first
  // tick after a load comes within one slow period
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prescale <= 8'h00;
      timer_cnt <= 16'h0000;
      timer_end_pulse <= 1'b0;
    end else begin
      prescale <= prescale + 8'h01;
      timer_end_pulse <= timer_end;
      if (wr_hit(OFS_TMR_LO)) begin
        timer_cnt <= {tmr_hi, reg_wdata};
      end else if (slow_tick && (timer_cnt != 16'h0000)) begin
        timer_cnt <= timer_cnt - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------------
  // set wins over a write-one clear in the same cycle
  always_comb begin
    next_flags = event_flags;
    next_flags2 = event_flags2;
    if (wr_hit(OFS_FLAG1)) begin
      next_flags[BIT_LOCK] = event_flags[BIT_LOCK] & ~reg_wdata[BIT_LOCK];
      next_flags[BIT_ADC_MUTE] = event_flags[BIT_ADC_MUTE] & ~reg_wdata[BIT_ADC_MUTE];
      next_flags[BIT_DAC_MUTE] = event_flags[BIT_DAC_MUTE] & ~reg_wdata[BIT_DAC_MUTE];
    end
    if (wr_hit(OFS_FLAG2)) begin
      next_flags2[BIT_TIMER_END] = event_flags2[BIT_TIMER_END] & ~reg_wdata[BIT_TIMER_END];
    end
    // masks do not gate flag setting
    if (lock_event) begin
      next_flags[BIT_LOCK] = 1'b1;
    end
    if (adc_mute_active != adc_mute_d) begin
      next_flags[BIT_ADC_MUTE] = 1'b1;
    end
    if (dac_mute_active != dac_mute_d) begin
      next_flags[BIT_DAC_MUTE] = 1'b1;
    end
    if (timer_end) begin
      next_flags2[BIT_TIMER_END] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      event_flags <= 8'h00;
      event_flags2 <= 8'h00;
      adc_mute_d <= 1'b0;
      dac_mute_d <= 1'b0;
    end else begin
      event_flags <= next_flags;
      event_flags2 <= next_flags2;
      adc_mute_d <= adc_mute_active;
      dac_mute_d <= dac_mute_active;
    end
  end

  // ----------------------------------------------------------------------
  // parallel clock sampling for pulse length
  // ----------------------------------------------------------------------
  // the pin clock is far slower than mclk; its rising edges are counted
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pclk_s1 <= 1'b0;
      pclk_s2 <= 1'b0;
      pclk_s3 <= 1'b0;
    end else begin
      pclk_s1 <= parallel_port_clock;
      pclk_s2 <= pclk_s1;
      pclk_s3 <= pclk_s2;
    end
  end

  // with the parallel interface selected, if the host stops its clock the pulse never ends
  assign pulse_tick = parallel_port_sel ? (pclk_s2 && !pclk_s3) : 1'b1;

  // ----------------------------------------------------------------------
  // interrupt line
  // ----------------------------------------------------------------------
  assign pending = any_pending(event_flags, event_masks, event_flags2, event_masks2);
  assign unmasked = {event_flags2 & ~event_masks2, event_flags & ~event_masks};
  // a new unmasked bit, by event or by unmasking, starts a pulse
  assign trigger = |(unmasked & ~unmasked_d);

  // pulse length counter; a retrigger restarts the full length
  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (trigger) begin
      next_pulse_cnt = 4'(IRQ_PULSE_LEN);
    end else if (pulse_tick && (pulse_cnt != 4'h0)) begin
      next_pulse_cnt = pulse_cnt - 4'h1;
    end
  end

  // line is registered so it never glitches while flags settle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pulse_cnt <= 4'h0;
      unmasked_d <= 16'h0000;
      irq_out <= 1'b0;
    end else begin
      pulse_cnt <= next_pulse_cnt;
      unmasked_d <= unmasked;
      unique case (irq_waveform_sel)
        CCTR_IRQ_LVL_HIGH: irq_out <= pending;
        CCTR_IRQ_LVL_LOW: irq_out <= !pending;
        CCTR_IRQ_PLS_HIGH: irq_out <= (next_pulse_cnt != 4'h0);
        CCTR_IRQ_PLS_LOW: irq_out <= (next_pulse_cnt == 4'h0);
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  // unmapped offsets read zero; reserved mask bits read one
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CLK_CTRL: reg_rdata <= {1'b0, clk_div, 1'b0, master_clock_gate, freq_sel};
        OFS_DAC_SEL: reg_rdata <= {4'h0, dac_sel};
        OFS_TUNE_HI: reg_rdata <= {dac_tune_enable, tune_word[TUNE_W-1:8]};
        OFS_TUNE_LO: reg_rdata <= tune_word[7:0];
        OFS_ADC_SEL: reg_rdata <= {1'b0, hpf, 2'b00, adc_sel};
        OFS_TMR_HI: reg_rdata <= tmr_hi;
        OFS_TMR_LO: reg_rdata <= tmr_lo;
        OFS_IRQ_FORM: reg_rdata <= {irq_waveform_sel, 6'h00};
        OFS_MASK1: reg_rdata <= MASK1_RSVD | event_masks;
        OFS_FLAG1: reg_rdata <= event_flags;
        OFS_MASK2: reg_rdata <= MASK2_RSVD | event_masks2;
        OFS_FLAG2: reg_rdata <= event_flags2;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_gate_low: assert property (@(posedge mclk) disable iff (!resetn)
    master_clock_gate |-> !master_clock_out) else $error("gated master clock not low");
  a_timer_end: assert property (@(posedge mclk) disable iff (!resetn)
    (slow_tick && (timer_cnt == 16'h0001) && !(reg_wr && (reg_addr == OFS_TMR_LO)))
    |=> ((timer_cnt == 16'h0000) && event_flags2[BIT_TIMER_END])) else $error("timer end event missing");
  a_level_idle: assert property (@(posedge mclk) disable iff (!resetn)
    ((irq_waveform_sel == CCTR_IRQ_LVL_HIGH) && (unmasked == 16'h0000)) |=> !irq_out)
    else $error("level irq active with nothing pending");
  a_flag_sets: assert property (@(posedge mclk) disable iff (!resetn)
    lock_event |=> event_flags[BIT_LOCK]) else $error("lock flag not set");
  a_flag_clear: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr && (reg_addr == OFS_FLAG1) && reg_wdata[BIT_LOCK] && !lock_event) |=> !event_flags[BIT_LOCK])
    else $error("lock flag not cleared");
  a_pulse_load: assert property (@(posedge mclk) disable iff (!resetn)
    trigger |=> (pulse_cnt == 4'(IRQ_PULSE_LEN))) else $error("pulse length not loaded");
  a_pulse_hold: assert property (@(posedge mclk) disable iff (!resetn)
    ((pulse_cnt != 4'h0) && !trigger && !pulse_tick) |=> (pulse_cnt == $past(pulse_cnt)))
    else $error("pulse counted without a tick");
  a_mask_rsvd: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && (reg_addr == OFS_MASK1)) |=> ((reg_rdata & MASK1_RSVD) == MASK1_RSVD))
    else $error("reserved mask bits not one");

endmodule : cctr_regs

// ==== testbench/cctr_host.sv ====
/*
  host side model: drives the register port of the codec register slice and
  the parallel control interface clock.
  assumes the bench calls wr and rd; reads return data one cycle later.
*/
`timescale 1ns/10ps

module cctr_host (
  input wire logic mclk, // master clock
  output logic [7:0] reg_addr, // register index
  output logic [7:0] reg_wdata, // write data
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  output logic parallel_port_clock // interface clock, 50 MHz
);
  // ----------------------------------------------------------------------
  // interface clock
  // ----------------------------------------------------------------------
  // free running, never stopped, so irq pulses can propagate
  initial parallel_port_clock = 1'b0;
  always #10 parallel_port_clock = ~parallel_port_clock;

  // idle bus values at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ----------------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------------
  // one-cycle strobe; idle lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // data is taken half a cycle after the edge that accepts the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : cctr_host

// ==== testbench/test_cctr_regs.sv ====
/*
  self-checking bench for the codec clock, timer and irq register slice.
  assumes cctr_host drives the register port; events driven at falling edge.
*/
`timescale 1ns/10ps

module test_cctr_regs;
  import cctr_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} cctr_row_t;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic parallel_port_sel = 1'b0;
  logic master_mode = 1'b1;
  logic lock_event = 1'b0;
  logic adc_mute_active = 1'b0;
  logic dac_mute_active = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, parallel_port_clock, master_clock_out, master_clock_freq_rsvd;
  logic [3:0] master_clock_freq_sel, dac_rate_code, adc_rate_code;
  logic adc_highpass_enable, dac_tune_active, timer_end_pulse, irq_out, last;
  logic [14:0] dac_tune_word;
  int n_errors = 0;
  int total_checks = 0;
  int k;
  cctr_row_t rows[9];

  always #2 mclk = ~mclk;

  cctr_host host_u (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .parallel_port_clock);
  cctr_regs dut_u (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .parallel_port_sel, .parallel_port_clock, .master_mode, .lock_event, .adc_mute_active,
    .dac_mute_active, .master_clock_out, .master_clock_freq_sel, .master_clock_freq_rsvd,
    .dac_rate_code, .adc_rate_code, .adc_highpass_enable, .dac_tune_word, .dac_tune_active,
    .timer_end_pulse, .irq_out);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rv);
    chk({8'h00, rv}, {8'h00, e});
  endtask : rchk

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // bounded wait for a level on irq_out; a hang counts as a mismatch
  task automatic wait_irq(input logic v);
    k = 0;
    while (irq_out !== v && k < 1000) begin
      @(negedge mclk);
      k++;
    end
    if (k == 1000) begin
      n_errors++;
      summarize();
    end
  endtask : wait_irq

  task automatic ev();
    @(negedge mclk);
    lock_event = 1'b1;
    @(negedge mclk);
    lock_event = 1'b0;
  endtask : ev

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rows = '{'{OFS_DAC_SEL, 8'hFF, 8'h0F}, '{OFS_TUNE_HI, 8'hFF, 8'hFF}, '{OFS_TUNE_LO, 8'hA5, 8'hA5},
      '{OFS_ADC_SEL, 8'hFF, 8'h4F}, '{OFS_TMR_HI, 8'h12, 8'h12}, '{OFS_TMR_LO, 8'h34, 8'h34},
      '{OFS_IRQ_FORM, 8'hFF, 8'hC0}, '{OFS_MASK1, 8'h00, 8'h7A}, '{OFS_MASK2, 8'h00, 8'hEF}};
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    rchk(OFS_CLK_CTRL, 8'h40);
    rchk(OFS_MASK1, 8'hFF);
    rchk(OFS_MASK2, 8'hFF);
    $display("reset test done");
    // readback with reserved bits forced
    foreach (rows[i]) begin
      host_u.wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    chk(dac_rate_code, 4'hF);
    chk(adc_rate_code, 4'hF);
    chk(adc_highpass_enable, 1'b1);
    chk({dac_tune_active, dac_tune_word}, 16'hFFA5);
    host_u.wr(OFS_TUNE_HI, 8'h7F);
    host_u.wr(OFS_ADC_SEL, 8'h0F);
    @(negedge mclk); // outputs are registered once more
    chk({dac_tune_active, adc_highpass_enable}, 2'b00);
    $display("table test done");
    // gated clock stays low, halved clock alternates
    host_u.wr(OFS_CLK_CTRL, 8'h50);
    k = 0;
    repeat (8) begin
      @(negedge mclk);
      k += master_clock_out;
    end
    chk(k, 0);
    host_u.wr(OFS_CLK_CTRL, 8'h40);
    repeat (2) @(negedge mclk);
    last = master_clock_out;
    k = 0;
    repeat (16) begin
      @(negedge mclk);
      k += (master_clock_out !== last);
      last = master_clock_out;
    end
    chk(k, 16);
    host_u.wr(OFS_CLK_CTRL, 8'h41);
    chk(master_clock_freq_rsvd, 1'b1);
    host_u.wr(OFS_CLK_CTRL, 8'h42);
    chk({master_clock_freq_sel, master_clock_freq_rsvd}, {FREQ_13MHZ, 1'b0});
    host_u.wr(OFS_CLK_CTRL, 8'h40);
    $display("clock test done");
    // masked event sets flag only; unmask raises level irq
    host_u.wr(OFS_IRQ_FORM, 8'h00);
    host_u.wr(OFS_MASK1, 8'hFF);
    host_u.wr(OFS_MASK2, 8'hFF);
    host_u.wr(OFS_FLAG1, 8'hFF);
    host_u.wr(OFS_FLAG2, 8'hFF);
    ev();
    chk(irq_out, 1'b0);
    host_u.wr(OFS_FLAG1, 8'h7F);
    rchk(OFS_FLAG1, 8'h80);
    host_u.wr(OFS_MASK1, 8'h7F);
    wait_irq(1'b1);
    host_u.wr(OFS_FLAG1, 8'h80);
    wait_irq(1'b0);
    rchk(OFS_FLAG1, 8'h00);
    host_u.wr(OFS_IRQ_FORM, 8'h40);
    wait_irq(1'b1);
    ev();
    wait_irq(1'b0);
    host_u.wr(OFS_FLAG1, 8'h80);
    // high pulse of eight master clocks, then silence until unmask
    host_u.wr(OFS_IRQ_FORM, 8'h80);
    wait_irq(1'b0);
    ev();
    wait_irq(1'b1);
    k = 0;
    while (irq_out === 1'b1 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    chk(k, IRQ_PULSE_LEN);
    repeat (20) @(negedge mclk);
    chk(irq_out, 1'b0);
    host_u.wr(OFS_MASK1, 8'hFF);
    host_u.wr(OFS_MASK1, 8'h7F);
    wait_irq(1'b1);
    host_u.wr(OFS_FLAG1, 8'h80);
    host_u.wr(OFS_IRQ_FORM, 8'h00);
    host_u.wr(OFS_MASK1, 8'hFF);
    $display("irq test done");
    // mute start and end each set the flags
    adc_mute_active = 1'b1;
    dac_mute_active = 1'b1;
    repeat (4) @(negedge mclk);
    rchk(OFS_FLAG1, 8'h05);
    host_u.wr(OFS_FLAG1, 8'h05);
    adc_mute_active = 1'b0;
    dac_mute_active = 1'b0;
    repeat (4) @(negedge mclk);
    rchk(OFS_FLAG1, 8'h05);
    host_u.wr(OFS_FLAG1, 8'h05);
    $display("mute test done");
    // timer load of two expires after two slow ticks
    host_u.wr(OFS_MASK2, 8'hEF);
    host_u.wr(OFS_TMR_HI, 8'h00);
    host_u.wr(OFS_TMR_LO, 8'h02);
    k = 0;
    while (timer_end_pulse !== 1'b1 && k < 1000) begin
      @(negedge mclk);
      k++;
    end
    chk(k >= SLOW_CLK_DIV && k <= 3 * SLOW_CLK_DIV, 1'b1);
    rchk(OFS_FLAG2, 8'h10);
    wait_irq(1'b1);
    host_u.wr(OFS_FLAG2, 8'h10);
    wait_irq(1'b0);
    $display("timer test done");
    summarize();
  end
endmodule : test_cctr_regs
